// >>> pkg/uetc_map.svh
// Purpose: register indices, field positions and reset values
//          of the endpoint toggle and address control block.
// Assumes: registers sit at byte address four times the index.
// Notes:   types live in uetc_pkg.

`ifndef UETC_MAP_SVH
`define UETC_MAP_SVH

`define UETC_IDX_TOGGLE_CONTROL   16'hC7D7
`define UETC_IDX_FRAME_LOW        16'hC7D8
`define UETC_IDX_FRAME_HIGH       16'hC7D9
`define UETC_IDX_FUNCTION_ADDRESS 16'hC7DB
`define UETC_IDX_PAIRING          16'hC7DD
`define UETC_IDX_IN_ENABLE        16'hC7DE

`define UETC_TOG_VALUE_BIT 7
`define UETC_TOG_SET_BIT   6
`define UETC_TOG_RESET_BIT 5
`define UETC_TOG_DIR_BIT   4
`define UETC_ZERO_LEN_BIT  7
`define UETC_EP_LAST       3'h5
`define UETC_ISO_EP        4'h8
`define UETC_EP_MSB        2
`define UETC_PAIR_MSB      4
`define UETC_EN_MSB        5
`define UETC_IDX_MSB       17
`define UETC_IDX_LSB       2

`define UETC_ZERO_BYTE  8'h00
`define UETC_ZERO_WORD  32'h0000_0000
`define UETC_HRESP_OKAY 1'b0

`endif

// >>> pkg/uetc_pkg.sv
// Purpose: shared types of the endpoint toggle and address control block.
// Assumes: nothing beyond uetc_map.svh.
// Notes:   bus states are Gray coded along idle, write, read, read-out.
package uetc_pkg;
    typedef enum logic [1:0] {
        UETC_IDLE = 2'h0,
        UETC_WR   = 2'h1,
        UETC_RD   = 2'h3,
        UETC_RDO  = 2'h2
    } uetc_bus_type;
endpackage

// >>> verif/uetc_host.sv
// Purpose: behavioural host side of the token and frame events.
// Assumes: calls start just after a rising edge.
// Notes:   released lines show the inverse of the last value; token leaves tok_in and iso_in_empty as they were.
`timescale 1ns/10ps
module uetc_host (
    input  wire logic   hclk,
    output logic        sof_valid,
    output logic [10:0] sof_frame,
    output logic        addr_valid,
    output logic [6:0]  addr_value,
    output logic        tok_valid,
    output logic        tok_in,
    output logic [6:0]  tok_addr,
    output logic [3:0]  tok_ep,
    output logic        iso_in_empty,
    output logic        done_valid,
    output logic        done_in,
    output logic [2:0]  done_ep
);
    initial begin
        {sof_valid, sof_frame, addr_valid, addr_value} = '0;
        {tok_valid, tok_in, tok_addr, tok_ep, iso_in_empty} = '0;
        {done_valid, done_in, done_ep} = '0;
    end
    task sof(input logic [10:0] f);
        {sof_valid, sof_frame} <= {1'b1, f};
        @(posedge hclk);
        {sof_valid, sof_frame} <= {1'b0, ~f};
        @(posedge hclk);
    endtask
    task setaddr(input logic [6:0] a);
        {addr_valid, addr_value} <= {1'b1, a};
        @(posedge hclk);
        {addr_valid, addr_value} <= {1'b0, ~a};
        @(posedge hclk);
    endtask
    task token(input logic i, input logic [6:0] a, input logic [3:0] ep, input logic em);
        {tok_valid, tok_in, tok_addr, tok_ep, iso_in_empty} <= {1'b1, i, a, ep, em};
        @(posedge hclk);
        {tok_valid, tok_addr, tok_ep} <= {1'b0, ~a, ~ep};
        @(posedge hclk);
    endtask
    task done(input logic i, input logic [2:0] ep);
        {done_valid, done_in, done_ep} <= {1'b1, i, ep};
        @(posedge hclk);
        {done_valid, done_in, done_ep} <= {1'b0, ~i, ~ep};
        @(posedge hclk);
    endtask
endmodule

// >>> verif/uetc_props.sv
// Purpose: port checks of the toggle and address block.
// Assumes: one clock, asynchronous active-low reset.
// Notes:   bound from the testbench top.
`timescale 1ns/10ps
module uetc_props (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       tok_valid,
    input wire logic       tok_in,
    input wire logic [3:0] tok_ep,
    input wire logic       iso_in_empty,
    input wire logic       tok_answer,
    input wire logic       iso_zero_length,
    input wire logic [5:0] in_endpoint_enable
);
    logic wr_seen_ff;
    logic iso_req_ff;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_take;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence wr_take;
        hsel && hready && htrans[1] && hwrite;
    endsequence
    // Helpers line up with the registered answer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_seen_ff <= 1'b0;
            iso_req_ff <= 1'b0;
        end else begin
            wr_seen_ff <= hsel && hready && htrans[1] && hwrite;
            iso_req_ff <= tok_valid && tok_in && tok_ep == 4'h8 && iso_in_empty;
        end
    end
    rd_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (wr_take |=> hreadyout)
        else $error("write stalled");
    tok_cause_a: assert property (tok_answer |-> $past(tok_valid))
        else $error("answer without token");
    iso_with_ans_a: assert property (iso_zero_length |-> tok_answer)
        else $error("zero length without answer");
    iso_cause_a: assert property (iso_zero_length |-> iso_req_ff)
        else $error("zero length without empty iso token");
    iso_silent_a: assert property (iso_req_ff |-> tok_answer == iso_zero_length)
        else $error("empty iso answered with data");
    en_write_a: assert property ($changed(in_endpoint_enable) |-> $past(wr_seen_ff, 1))
        else $error("enables moved without write");
    in_off_a: assert property (tok_valid && tok_in && tok_ep < 4'h6
        && !in_endpoint_enable[tok_ep[2:0]] |=> !tok_answer)
        else $error("disabled endpoint answered");
endmodule

// >>> verif/usb_endpoint_toggle_addr_ctrl_tb.sv
// Purpose: self-checking bench of the toggle and address block.
// Assumes: one slave, so hready is hreadyout.
// Notes:   reads and tokens are scored from queues.
`timescale 1ns/10ps
`include "uetc_map.svh"
module usb_endpoint_toggle_addr_ctrl_tb;
    localparam logic [15:0] tog = `UETC_IDX_TOGGLE_CONTROL;
    localparam logic [15:0] pair = `UETC_IDX_PAIRING;
    localparam logic [15:0] inen = `UETC_IDX_IN_ENABLE;
    localparam logic [15:0] fa = `UETC_IDX_FUNCTION_ADDRESS;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, t;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic sof_valid, addr_valid, tok_valid, tok_in, iso_in_empty, done_valid, done_in;
    logic [10:0] sof_frame, f;
    logic [6:0] addr_value, tok_addr;
    logic [3:0] tok_ep;
    logic [2:0] done_ep;
    logic tok_answer, iso_zero_length, tok_toggle, pair_bulk_out_four_five;
    logic pair_bulk_out_two_three, pair_bulk_in_six_seven, pair_bulk_in_four_five;
    logic pair_bulk_in_two_three, rd_pend = 1'b0, tk_pend = 1'b0;
    logic [5:0] in_endpoint_enable;
    logic [7:0] v;
    logic [31:0] rq[$];
    logic [2:0] tq[$];
    int errors = 0;
    int tests_run = 0;
    uetc_top dut (.*, .hready(hreadyout));
    uetc_host host (.*);
    always #12.5 hclk = ~hclk;
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            errors++;
            print_verdict;
        end
    endtask
    task xfer(input logic w, input logic [15:0] idx, input logic [7:0] d);
        {hsel, hwrite, htrans, haddr} <= {1'b1, w, 2'h2, 14'h0000, idx, 2'h0};
        wait_rdy;
        {htrans, hwdata} <= {2'h0, 24'h000000, d};
        wait_rdy;
    endtask
    task rd(input logic [15:0] idx, input logic [7:0] e);
        rq.push_back({24'h000000, e});
        xfer(1'b0, idx, 8'h00);
    endtask
    task tok(input logic i, input logic [6:0] a, input logic [3:0] ep, input logic em,
             input logic [2:0] e);
        tq.push_back(e);
        host.token(i, a, ep, em);
    endtask
    always @(posedge hclk) begin
        if (rd_pend && hreadyout === 1'b1) begin
            chk("hrdata", hrdata, rq.pop_front());
            chk("hresp", 32'(hresp), 32'(`UETC_HRESP_OKAY));
        end
        if (hreadyout === 1'b1)
            rd_pend <= hsel && htrans[1] && !hwrite;
        if (tk_pend) begin
            t = tq.pop_front();
            chk("token", {tok_answer, iso_zero_length, tok_toggle & t[2]}, t);
        end
        tk_pend <= tok_valid;
    end
    initial begin
        void'($urandom(32'h4A8F));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(tog, 8'h00);
        rd(fa, 8'h00);
        rd(pair, 8'h00);
        rd(inen, 8'h00);
        rd(16'hC7D8, 8'h00);
        rd(16'h0001, 8'h00);
        $display("test reset done");
        for (int d = 0; d < 2; d++)
            for (int ep = 0; ep < 8; ep++) begin
                v = {3'h0, d[0], 1'b0, ep[2:0]};
                xfer(1'b1, tog, v | 8'h40);
                rd(tog, v | ((ep < 6) ? 8'h80 : 8'h00));
                xfer(1'b1, tog, v | 8'h20);
                rd(tog, v);
            end
        xfer(1'b1, tog, 8'h43);
        rd(tog, 8'h83);
        xfer(1'b1, tog, 8'h13);
        rd(tog, 8'h13);
        host.done(1'b1, 3'h3);
        rd(tog, 8'h93);
        $display("test toggle done");
        repeat (3) begin
            v = 8'($urandom) & 8'h9F;
            xfer(1'b1, pair, v | 8'h60);
            rd(pair, v);
            chk("pairs", {pair_bulk_out_four_five, pair_bulk_out_two_three,
                pair_bulk_in_six_seven, pair_bulk_in_four_five,
                pair_bulk_in_two_three}, v[4:0]);
        end
        xfer(1'b1, inen, 8'hF7);
        rd(inen, 8'h37);
        chk("enables", in_endpoint_enable, 6'h37);
        $display("test pairing done");
        for (int i = 0; i < 3; i++) begin
            f = (i == 0) ? 11'h3FF : (i == 1) ? 11'h000 : 11'($urandom);
            host.sof(f);
            xfer(1'b1, 16'hC7D8, 8'hAA);
            xfer(1'b1, 16'hC7D9, 8'h05);
            rd(16'hC7D8, f[7:0]);
            rd(16'hC7D9, {5'h00, f[10:8]});
        end
        $display("test frame done");
        tok(1'b0, 7'h00, 4'h1, 1'b0, 3'h4);
        host.setaddr(7'h2A);
        xfer(1'b1, fa, 8'h11);
        rd(fa, 8'h2A);
        tok(1'b0, 7'h15, 4'h1, 1'b0, 3'h0);
        tok(1'b0, 7'h2A, 4'h1, 1'b0, 3'h4);
        tok(1'b1, 7'h2A, 4'h3, 1'b0, 3'h0);
        xfer(1'b1, inen, 8'h3F);
        tok(1'b1, 7'h2A, 4'h3, 1'b0, 3'h5);
        xfer(1'b1, pair, 8'h00);
        tok(1'b1, 7'h2A, 4'h8, 1'b1, 3'h0);
        xfer(1'b1, pair, 8'h80);
        tok(1'b1, 7'h2A, 4'h8, 1'b1, 3'h6);
        tok(1'b1, 7'h2A, 4'h8, 1'b0, 3'h4);
        repeat (2) @(posedge hclk);
        chk("pending", 32'(rq.size() + tq.size()), 32'h0000_0000);
        $display("test token done");
        print_verdict;
    end
endmodule
bind uetc_top uetc_props u_props (.*);

// >>> verilog/uetc_top.sv
// Purpose: AHB-Lite register file for data toggles, frame number,
//          function address, pairing and IN enables, plus token filter.
// Assumes: USB core signals arrive on hclk; one-cycle pulses.
// Notes:   reads take one wait state, writes none.
`timescale 1ns/10ps
`include "uetc_map.svh"

module uetc_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,

    input  wire logic        sof_valid,
    input  wire logic [10:0] sof_frame,
    input  wire logic        addr_valid,
    input  wire logic [6:0]  addr_value,

    input  wire logic        tok_valid,
    input  wire logic        tok_in,
    input  wire logic [6:0]  tok_addr,
    input  wire logic [3:0]  tok_ep,
    input  wire logic        iso_in_empty,

    input  wire logic        done_valid,
    input  wire logic        done_in,
    input  wire logic [2:0]  done_ep,

    output logic             tok_answer,
    output logic             iso_zero_length,
    output logic             tok_toggle,

    output logic             pair_bulk_out_four_five,
    output logic             pair_bulk_out_two_three,
    output logic             pair_bulk_in_six_seven,
    output logic             pair_bulk_in_four_five,
    output logic             pair_bulk_in_two_three,
    output logic [5:0]       in_endpoint_enable
);

    // Bus side state
    uetc_pkg::uetc_bus_type state_ff;
    uetc_pkg::uetc_bus_type nxt_state;
    logic [15:0] idx_ff;
    logic        ok_ff;
    logic        ready_ff;
    logic [31:0] rdata_ff;

    // Register contents
    logic [5:0]  tog_in_ff;
    logic [5:0]  tog_out_ff;
    logic [5:0]  nxt_tog_in;
    logic [5:0]  nxt_tog_out;
    logic        dir_ff;
    logic [2:0]  ep_ff;
    logic [10:0] frame_ff;
    logic [6:0]  fnaddr_ff;
    logic        zero_len_ff;
    logic [4:0]  pair_ff;
    logic [5:0]  in_en_ff;

    // Token answer
    logic        answer_ff;
    logic        zlp_ff;
    logic        tok_tog_ff;

    // Address phase decode
    wire         take;
    wire         addr_ok;
    wire [15:0]  idx_now;

    // hsize is not decoded; only whole words are mapped
    assign take    = hsel & hready & htrans[1];
    assign idx_now = haddr[`UETC_IDX_MSB:`UETC_IDX_LSB];
    // Upper bits must be zero so no alias of the map hits
    assign addr_ok = (haddr[31:(`UETC_IDX_MSB + 1)] == 14'h0000) &
                     (haddr[(`UETC_IDX_LSB - 1):0] == 2'h0);

    // Data phase decode on the latched index
    wire         wr_phase;
    wire         hit_tog;
    wire         hit_flo;
    wire         hit_fhi;
    wire         hit_fna;
    wire         hit_pair;
    wire         hit_inen;

    assign wr_phase = (state_ff == uetc_pkg::UETC_WR);
    assign hit_tog  = ok_ff & (idx_ff == `UETC_IDX_TOGGLE_CONTROL);
    assign hit_flo  = ok_ff & (idx_ff == `UETC_IDX_FRAME_LOW);
    assign hit_fhi  = ok_ff & (idx_ff == `UETC_IDX_FRAME_HIGH);
    assign hit_fna  = ok_ff & (idx_ff == `UETC_IDX_FUNCTION_ADDRESS);
    assign hit_pair = ok_ff & (idx_ff == `UETC_IDX_PAIRING);
    assign hit_inen = ok_ff & (idx_ff == `UETC_IDX_IN_ENABLE);

    // Write strobes; frame and address registers have none
    wire         wr_tog;
    wire         wr_pair;
    wire         wr_inen;

    assign wr_tog  = wr_phase & hit_tog;
    assign wr_pair = wr_phase & hit_pair;
    assign wr_inen = wr_phase & hit_inen;

    // Toggle control write fields
    wire [2:0]   w_ep;
    wire         w_dir;
    wire         w_set;
    wire         w_rst;
    wire         w_ep_ok;

    assign w_ep    = hwdata[`UETC_EP_MSB:0];
    assign w_dir   = hwdata[`UETC_TOG_DIR_BIT];
    assign w_set   = hwdata[`UETC_TOG_SET_BIT];
    assign w_rst   = hwdata[`UETC_TOG_RESET_BIT];
    assign w_ep_ok = (w_ep <= `UETC_EP_LAST);

    // Pairing and enable write fields
    wire         w_zero_len;
    wire [4:0]   w_pair;
    wire [5:0]   w_en;

    assign w_zero_len = hwdata[`UETC_ZERO_LEN_BIT];
    assign w_pair     = hwdata[`UETC_PAIR_MSB:0];
    assign w_en       = hwdata[`UETC_EN_MSB:0];

    // Selected toggle; numbers six and seven read DATA0
    wire         sel_ok;
    wire         sel_tog;

    assign sel_ok  = (ep_ff <= `UETC_EP_LAST);
    assign sel_tog = !sel_ok ? 1'b0 :
                     dir_ff  ? tog_in_ff[ep_ff] :
                               tog_out_ff[ep_ff];

    // Read values
    wire [7:0]   rd_tog;
    wire [7:0]   rd_flo;
    wire [7:0]   rd_fhi;
    wire [7:0]   rd_fna;
    wire [7:0]   rd_pair;
    wire [7:0]   rd_inen;
    wire [7:0]   rd_byte;

    // Set and reset bits are actions and read back as zero
    assign rd_tog  = {sel_tog, 2'h0, dir_ff, 1'b0, ep_ff};
    assign rd_flo  = frame_ff[7:0];
    assign rd_fhi  = {5'h00, frame_ff[10:8]};
    assign rd_fna  = {1'b0, fnaddr_ff};
    assign rd_pair = {zero_len_ff, 2'h0, pair_ff};
    assign rd_inen = {2'h0, in_en_ff};

    assign rd_byte = hit_tog  ? rd_tog  :
                     hit_flo  ? rd_flo  :
                     hit_fhi  ? rd_fhi  :
                     hit_fna  ? rd_fna  :
                     hit_pair ? rd_pair :
                     hit_inen ? rd_inen :
                                `UETC_ZERO_BYTE;

    // Bus phases; a read waits one cycle so the toggle bit
    // reflects a selection written by the transfer just before
    always_comb begin
        nxt_state = uetc_pkg::UETC_IDLE;
        case (state_ff)
            uetc_pkg::UETC_RD: begin
                nxt_state = uetc_pkg::UETC_RDO;
            end
            default: begin
                if (take) begin
                    nxt_state = hwrite ? uetc_pkg::UETC_WR
                                       : uetc_pkg::UETC_RD;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= uetc_pkg::UETC_IDLE;
            ready_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            ready_ff <= (nxt_state != uetc_pkg::UETC_RD);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_ff <= 16'h0000;
            ok_ff  <= 1'b0;
        end else if (take) begin
            idx_ff <= idx_now;
            ok_ff  <= addr_ok;
        end
    end

    // Unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= `UETC_ZERO_WORD;
        end else if (state_ff == uetc_pkg::UETC_RD) begin
            rdata_ff <= {24'h000000, rd_byte};
        end
    end

    // Toggle selection; software writes it before reading
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dir_ff <= 1'b0;
            ep_ff  <= 3'h0;
        end else if (wr_tog) begin
            dir_ff <= w_dir;
            ep_ff  <= w_ep;
        end
    end

    // Data toggles; a software force beats a transfer flip
    // in the same cycle, since firmware forces on purpose
    always_comb begin
        nxt_tog_in  = tog_in_ff;
        nxt_tog_out = tog_out_ff;
        if (done_valid && (done_ep <= `UETC_EP_LAST)) begin
            if (done_in) begin
                nxt_tog_in[done_ep] = ~tog_in_ff[done_ep];
            end else begin
                nxt_tog_out[done_ep] = ~tog_out_ff[done_ep];
            end
        end
        if (wr_tog && w_ep_ok && (w_set || w_rst)) begin
            if (w_dir) begin
                nxt_tog_in[w_ep] = w_set;
            end else begin
                nxt_tog_out[w_ep] = w_set;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tog_in_ff  <= 6'h00;
            tog_out_ff <= 6'h00;
        end else begin
            tog_in_ff  <= nxt_tog_in;
            tog_out_ff <= nxt_tog_out;
        end
    end

    // Frame number; only the core writes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_ff <= 11'h000;
        end else if (sof_valid) begin
            frame_ff <= sof_frame;
        end
    end

    // Function address; only the core writes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fnaddr_ff <= 7'h00;
        end else if (addr_valid) begin
            fnaddr_ff <= addr_value;
        end
    end

    // Pairing and iso policy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero_len_ff <= 1'b0;
            pair_ff     <= 5'h00;
        end else if (wr_pair) begin
            zero_len_ff <= w_zero_len;
            pair_ff     <= w_pair;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_en_ff <= 6'h00;
        end else if (wr_inen) begin
            in_en_ff <= w_en;
        end
    end

    // Token filter
    wire         tok_match;
    wire         tok_low;
    wire         tok_iso;
    wire         tok_ok_in;
    wire         tok_zlp;
    wire         tok_sel_tog;

    assign tok_match = (tok_addr == fnaddr_ff);
    assign tok_low   = (tok_ep <= {1'b0, `UETC_EP_LAST});
    assign tok_iso   = (tok_ep == `UETC_ISO_EP);
    assign tok_zlp   = tok_in & tok_iso & iso_in_empty & zero_len_ff;

    // Empty iso without the bit stays silent
    assign tok_ok_in = !tok_in  ? 1'b1 :
                       tok_low  ? in_en_ff[tok_ep[2:0]] :
                       tok_iso  ? (~iso_in_empty | zero_len_ff) :
                                  1'b1;

    assign tok_sel_tog = !tok_low ? 1'b0 :
                         tok_in   ? tog_in_ff[tok_ep[2:0]] :
                                    tog_out_ff[tok_ep[2:0]];

    // Registered answer costs a cycle but keeps the outputs clean
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            answer_ff  <= 1'b0;
            zlp_ff     <= 1'b0;
            tok_tog_ff <= 1'b0;
        end else begin
            answer_ff  <= tok_valid & tok_match & tok_ok_in;
            zlp_ff     <= tok_valid & tok_match & tok_zlp;
            tok_tog_ff <= tok_sel_tog;
        end
    end

    // Outputs straight from flip-flops, except hresp, which is tied to OKAY
    assign hreadyout               = ready_ff;
    assign hrdata                  = rdata_ff;
    assign hresp                   = `UETC_HRESP_OKAY;
    assign tok_answer              = answer_ff;
    assign iso_zero_length         = zlp_ff;
    // Toggle follows every cycle; only meaningful with an answer
    assign tok_toggle              = tok_tog_ff;
    assign pair_bulk_out_four_five = pair_ff[4];
    assign pair_bulk_out_two_three = pair_ff[3];
    assign pair_bulk_in_six_seven  = pair_ff[2];
    assign pair_bulk_in_four_five  = pair_ff[1];
    assign pair_bulk_in_two_three  = pair_ff[0];
    assign in_endpoint_enable      = in_en_ff;

endmodule
